// >>> logic/bfp_consts.svh
// Constants of the batch front-panel controller: offsets, fields, reset values and timing.
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH
`define BFP_CLK_HZ 25000000
`define BFP_LABEL_MS 1000
`define BFP_REFRESH_MS 250
`define BFP_PULSE_MS 10
`define BFP_PULSE_MAX_PPS 49
`define BFP_RATE_MIN_MHZ 250
`define BFP_DEBOUNCE_MS 5
`define BFP_LIN_POINTS 10
`define BFP_K_UNITY 16'h1000
`define BFP_REG_CTRL 8'h00
`define BFP_REG_LIMIT 8'h04
`define BFP_REG_QTY 8'h08
`define BFP_REG_BTOT 8'h0C
`define BFP_REG_GTOT 8'h10
`define BFP_REG_RATE 8'h14
`define BFP_REG_STAT 8'h18
`define BFP_REG_LIN_NUM 8'h1C
`define BFP_REG_LIN_BASE 8'h20
`define BFP_CTRL_DOWN_BIT 0
`define BFP_CTRL_AUTO_BIT 1
`define BFP_CTRL_QUAD_BIT 2
`define BFP_CTRL_RST 3'h0
`define BFP_LIMIT_RST 24'h000000
`define BFP_QTY_RST 24'h000000
`define BFP_LIN_NUM_RST 4'h0
`define BFP_MSD_IDX 3'h5
`endif

// >>> logic/bfp_pkg.sv
// Types shared by the batch front-panel controller and its bench.
package bfp_pkg;
  typedef logic [23:0] bfp_bcd_t;
  typedef enum logic [3:0] {
    BFP_READY = 4'b0001,
    BFP_RUN = 4'b0010,
    BFP_PAUSE = 4'b0100,
    BFP_DONE = 4'b1000
  } bfp_batch_e;
  typedef enum logic [3:0] {
    BFP_V_TOTAL = 4'b0001,
    BFP_V_RATE = 4'b0010,
    BFP_V_GRAND = 4'b0100,
    BFP_V_QTY = 4'b1000
  } bfp_view_e;
  typedef enum logic [2:0] {
    BFP_L_NONE = 3'h0,
    BFP_L_BATCH = 3'h1,
    BFP_L_SET = 3'h2,
    BFP_L_RATE = 3'h3,
    BFP_L_GRAND = 3'h4
  } bfp_label_e;
  typedef struct packed {
    logic batch;
    logic display;
    logic run;
    logic stop;
  } bfp_keys_s;
  typedef struct packed {
    bfp_bcd_t digits;
    logic [5:0] blank;
    bfp_label_e label;
  } bfp_disp_s;
endpackage

// >>> logic/bfp_panel.sv
// Batch front-panel controller: keys, batch sequencing, totals, display and scaled pulse output.
`timescale 1ns/1ns
`include "bfp_consts.svh"
module bfp_panel import bfp_pkg::*; #(
  parameter int unsigned LABEL_CYC = (`BFP_CLK_HZ / 1000) * `BFP_LABEL_MS,
  parameter int unsigned REFRESH_CYC = (`BFP_CLK_HZ / 1000) * `BFP_REFRESH_MS,
  parameter int unsigned PULSE_LOW_CYC = (`BFP_CLK_HZ / 1000) * `BFP_PULSE_MS,
  parameter int unsigned PULSE_GAP_CYC = (`BFP_CLK_HZ + `BFP_PULSE_MAX_PPS - 1) / `BFP_PULSE_MAX_PPS,
  parameter int unsigned RATE_GATE_CYC = (`BFP_CLK_HZ / `BFP_RATE_MIN_MHZ) * 1000,
  parameter int unsigned DEBOUNCE_CYC = (`BFP_CLK_HZ / 1000) * `BFP_DEBOUNCE_MS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire bfp_keys_s KEYS,
  input wire logic FLOW_A,
  input wire logic FLOW_B,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output bfp_disp_s DISP,
  output logic LED_BATCH,
  output logic LED_RUN,
  output logic LED_STOP,
  output logic RELAY_1,
  output logic RELAY_2,
  output logic PULSE_OUT_N
);

  function automatic bfp_bcd_t bcd_step(input bfp_bcd_t v, input logic down);
    logic carry;
    bcd_step = v;
    carry = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (carry) begin
        if (down) begin
          carry = (v[i*4 +: 4] == 4'h0);
          bcd_step[i*4 +: 4] = carry ? 4'h9 : v[i*4 +: 4] - 4'h1;
        end else begin
          carry = (v[i*4 +: 4] == 4'h9);
          bcd_step[i*4 +: 4] = carry ? 4'h0 : v[i*4 +: 4] + 4'h1;
        end
      end
    end
  endfunction

  logic [3:0] press_v;
  bfp_keys_s press;
  bfp_batch_e state_ff;
  bfp_view_e view_ff;
  bfp_label_e label_ff;
  bfp_bcd_t qty_ff, limit_ff, edit_qty_ff, btot_ff, gtot_ff, rate_bcd_ff, rate_cnt_bcd_ff;
  logic [2:0] ctrl_ff;
  logic [3:0] lin_num_ff;
  logic [31:0] lin_ff [`BFP_LIN_POINTS];
  logic edit_ff, phase_ff, wait_ff;
  logic [2:0] sel_ff;
  logic [31:0] label_cnt_ff, refresh_cnt_ff, gate_cnt_ff, per_cnt_ff;
  logic [15:0] rate_bin_ff, rate_cnt_ff, k_ff, nxt_k, pend_ff;
  logic [23:0] frac_ff;
  logic a_s1_ff, a_s2_ff, a_prev_ff, b_s1_ff, b_s2_ff;
  logic flow_pulse, unit, run_p, stop_p, commit, reject, bus_wr;
  logic [31:0] rd_mux;
  bfp_bcd_t rst_total, step_total;
  logic down_mode;

  assign press = press_v;
  assign down_mode = ctrl_ff[`BFP_CTRL_DOWN_BIT];

  // Each key is synchronised, then must hold a new level for the whole debounce time.
  for (genvar gi = 0; gi < 4; gi++) begin : g_key
    logic s1_ff, s2_ff, st_ff, prs_ff;
    logic [31:0] cnt_ff;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        st_ff <= 1'b0;
        prs_ff <= 1'b0;
        cnt_ff <= 32'h0;
      end else begin
        s1_ff <= KEYS[gi];
        s2_ff <= s1_ff;
        prs_ff <= 1'b0;
        if (s2_ff == st_ff) begin
          cnt_ff <= 32'h0;
        end else if (cnt_ff >= DEBOUNCE_CYC - 1) begin
          cnt_ff <= 32'h0;
          st_ff <= s2_ff;
          prs_ff <= s2_ff;
        end else begin
          cnt_ff <= cnt_ff + 32'h1;
        end
      end
    end
    assign press_v[gi] = prs_ff;
  end

  // Keys double as edit keys while a quantity is being entered.
  assign run_p = press.run & ~edit_ff;
  assign stop_p = press.stop & ~edit_ff;
  assign reject = (limit_ff != 24'h0) && (edit_qty_ff > limit_ff);
  assign commit = press.batch & edit_ff & (view_ff == BFP_V_QTY) & ~reject;

  // A 25 MHz sample of both lines resolves edges far faster than 10 kHz.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      a_s1_ff <= 1'b0;
      a_s2_ff <= 1'b0;
      a_prev_ff <= 1'b0;
      b_s1_ff <= 1'b0;
      b_s2_ff <= 1'b0;
    end else begin
      a_s1_ff <= FLOW_A;
      a_s2_ff <= a_s1_ff;
      a_prev_ff <= a_s2_ff;
      b_s1_ff <= FLOW_B;
      b_s2_ff <= b_s1_ff;
    end
  end
  // In quadrature mode only forward flow (B low at the A edge) is counted.
  assign flow_pulse = a_s2_ff & ~a_prev_ff & (~ctrl_ff[`BFP_CTRL_QUAD_BIT] | ~b_s2_ff);

  // Rate counts pulses over a four-second gate, so one count is 0.25 Hz and slower reads zero.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gate_cnt_ff <= 32'h0;
      rate_cnt_ff <= 16'h0;
      rate_cnt_bcd_ff <= 24'h0;
      rate_bin_ff <= 16'h0;
      rate_bcd_ff <= 24'h0;
    end else if (gate_cnt_ff >= RATE_GATE_CYC - 1) begin
      gate_cnt_ff <= 32'h0;
      rate_bin_ff <= rate_cnt_ff;
      rate_bcd_ff <= rate_cnt_bcd_ff;
      rate_cnt_ff <= 16'h0;
      rate_cnt_bcd_ff <= 24'h0;
    end else begin
      gate_cnt_ff <= gate_cnt_ff + 32'h1;
      if (flow_pulse && rate_cnt_ff != 16'hFFFF) begin
        rate_cnt_ff <= rate_cnt_ff + 16'h1;
        rate_cnt_bcd_ff <= bcd_step(rate_cnt_bcd_ff, 1'b0);
      end
    end
  end

  // Correction factor per pulse in 1/4096 units, interpolated between table points.
  always_comb begin
    longint dk, dr, span;
    dk = 0;
    dr = 0;
    span = 0;
    nxt_k = (lin_num_ff == 4'h0) ? `BFP_K_UNITY : lin_ff[0][15:0];
    for (int i = 0; i < `BFP_LIN_POINTS - 1; i++) begin
      if (i + 1 < int'(lin_num_ff) && rate_bin_ff >= lin_ff[i][31:16]) begin
        if (rate_bin_ff >= lin_ff[i+1][31:16] || lin_ff[i+1][31:16] <= lin_ff[i][31:16]) begin
          nxt_k = lin_ff[i+1][15:0];
        end else begin
          dk = longint'(lin_ff[i+1][15:0]) - longint'(lin_ff[i][15:0]);
          dr = longint'(rate_bin_ff) - longint'(lin_ff[i][31:16]);
          span = longint'(lin_ff[i+1][31:16]) - longint'(lin_ff[i][31:16]);
          nxt_k = 16'(longint'(lin_ff[i][15:0]) + dk * dr / span);
        end
      end
    end
  end

  // Scaled total: each pulse adds its factor, each whole unit drained is one count.
  assign unit = frac_ff >= 24'(`BFP_K_UNITY);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      k_ff <= `BFP_K_UNITY;
      frac_ff <= 24'h0;
    end else begin
      k_ff <= nxt_k;
      frac_ff <= frac_ff + (flow_pulse ? 24'(k_ff) : 24'h0) - (unit ? 24'(`BFP_K_UNITY) : 24'h0);
    end
  end

  // The grand total is cleared only by reset.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gtot_ff <= 24'h0;
    end else if (unit) begin
      gtot_ff <= bcd_step(gtot_ff, 1'b0);
    end
  end

  assign rst_total = down_mode ? qty_ff : 24'h0;
  assign step_total = bcd_step(btot_ff, down_mode);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= BFP_READY;
      btot_ff <= 24'h0;
    end else begin
      case (state_ff)
        BFP_READY: begin
          if (run_p) begin
            btot_ff <= rst_total;
            state_ff <= (qty_ff == 24'h0) ? BFP_DONE : BFP_RUN;
          end
        end
        BFP_RUN: begin
          if (stop_p) begin
            state_ff <= BFP_PAUSE;
          end else if (unit) begin
            btot_ff <= step_total;
            if (step_total == (down_mode ? 24'h0 : qty_ff)) begin
              state_ff <= BFP_DONE;
            end
          end
        end
        BFP_PAUSE: begin
          if (run_p) begin
            state_ff <= BFP_RUN;
          end else if (stop_p) begin
            btot_ff <= rst_total;
            state_ff <= BFP_READY;
          end
        end
        BFP_DONE: begin
          if (stop_p) begin
            btot_ff <= rst_total;
            state_ff <= BFP_READY;
          end else if (run_p && ctrl_ff[`BFP_CTRL_AUTO_BIT]) begin
            btot_ff <= rst_total;
            state_ff <= (qty_ff == 24'h0) ? BFP_DONE : BFP_RUN;
          end
        end
        default: state_ff <= BFP_READY;
      endcase
    end
  end

  // View, label and quantity entry.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      view_ff <= BFP_V_TOTAL;
      label_ff <= BFP_L_NONE;
      label_cnt_ff <= 32'h0;
      edit_ff <= 1'b0;
      sel_ff <= `BFP_MSD_IDX;
      edit_qty_ff <= 24'h0;
    end else begin
      if (label_cnt_ff != 32'h0) begin
        label_cnt_ff <= label_cnt_ff - 32'h1;
      end else begin
        label_ff <= BFP_L_NONE;
      end
      if (press.batch) begin
        label_cnt_ff <= LABEL_CYC - 1;
        if (view_ff != BFP_V_QTY || reject) begin
          view_ff <= BFP_V_QTY;
          label_ff <= BFP_L_BATCH;
          edit_ff <= (state_ff != BFP_RUN);
          sel_ff <= `BFP_MSD_IDX;
          edit_qty_ff <= qty_ff;
        end else begin
          view_ff <= BFP_V_TOTAL;
          label_ff <= BFP_L_SET;
          edit_ff <= 1'b0;
        end
      end else if (press.display && edit_ff) begin
        edit_qty_ff[{sel_ff, 2'b00} +: 4] <= (edit_qty_ff[{sel_ff, 2'b00} +: 4] == 4'h9) ? 4'h0 :
            edit_qty_ff[{sel_ff, 2'b00} +: 4] + 4'h1;
      end else if (press.run && edit_ff) begin
        sel_ff <= (sel_ff == 3'h0) ? `BFP_MSD_IDX : sel_ff - 3'h1;
      end else if (press.display && view_ff != BFP_V_QTY) begin
        label_cnt_ff <= LABEL_CYC - 1;
        case (view_ff)
          BFP_V_TOTAL: begin
            view_ff <= BFP_V_RATE;
            label_ff <= BFP_L_RATE;
          end
          BFP_V_RATE: begin
            view_ff <= BFP_V_GRAND;
            label_ff <= BFP_L_GRAND;
          end
          default: begin
            view_ff <= BFP_V_TOTAL;
            label_ff <= BFP_L_NONE;
          end
        endcase
      end
    end
  end

  // Display and lamps; flashing shares the refresh tick, so it blinks at 2 Hz.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      refresh_cnt_ff <= 32'h0;
      phase_ff <= 1'b0;
      DISP <= '0;
      LED_BATCH <= 1'b0;
      LED_RUN <= 1'b0;
      LED_STOP <= 1'b0;
      RELAY_1 <= 1'b0;
      RELAY_2 <= 1'b0;
    end else begin
      LED_BATCH <= (view_ff == BFP_V_QTY);
      LED_RUN <= (state_ff == BFP_RUN);
      LED_STOP <= (state_ff == BFP_PAUSE) & phase_ff;
      RELAY_1 <= (state_ff == BFP_RUN) & ~stop_p;
      RELAY_2 <= (state_ff == BFP_RUN) & ~stop_p;
      if (refresh_cnt_ff >= REFRESH_CYC - 1) begin
        refresh_cnt_ff <= 32'h0;
        phase_ff <= ~phase_ff;
        DISP.label <= label_ff;
        DISP.blank <= 6'h00;
        if (label_ff != BFP_L_NONE) begin
          DISP.digits <= 24'h0;
        end else begin
          case (view_ff)
            BFP_V_RATE: DISP.digits <= rate_bcd_ff;
            BFP_V_GRAND: DISP.digits <= gtot_ff;
            BFP_V_QTY: begin
              DISP.digits <= edit_qty_ff;
              if (~phase_ff) begin
                DISP.blank <= edit_ff ? 6'(6'h01 << sel_ff) : 6'h3F;
              end
            end
            default: DISP.digits <= btot_ff;
          endcase
        end
      end else begin
        refresh_cnt_ff <= refresh_cnt_ff + 32'h1;
      end
    end
  end

  // Output pulses queue up so a fast total never exceeds the pulse rate.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pend_ff <= 16'h0;
      per_cnt_ff <= 32'h0;
      PULSE_OUT_N <= 1'b1;
    end else begin
      if (per_cnt_ff == 32'h0 && pend_ff != 16'h0) begin
        per_cnt_ff <= PULSE_GAP_CYC - 1;
        PULSE_OUT_N <= 1'b0;
        pend_ff <= unit ? pend_ff : pend_ff - 16'h1;
      end else begin
        if (unit && pend_ff != 16'hFFFF) begin
          pend_ff <= pend_ff + 16'h1;
        end
        if (per_cnt_ff != 32'h0) begin
          per_cnt_ff <= per_cnt_ff - 32'h1;
        end
        if (per_cnt_ff == PULSE_GAP_CYC - PULSE_LOW_CYC) begin
          PULSE_OUT_N <= 1'b1;
        end
      end
    end
  end

  // Bus slave: one wait cycle, then the access completes.
  assign bus_wr = AVS_WRITE & ~wait_ff;
  always_comb begin
    rd_mux = 32'h0;
    if (AVS_ADDRESS[7:2] == `BFP_REG_CTRL >> 2) begin
      rd_mux = 32'(ctrl_ff);
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_LIMIT >> 2) begin
      rd_mux = 32'(limit_ff);
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_QTY >> 2) begin
      rd_mux = 32'(qty_ff);
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_BTOT >> 2) begin
      rd_mux = 32'(btot_ff);
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_GTOT >> 2) begin
      rd_mux = 32'(gtot_ff);
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_RATE >> 2) begin
      rd_mux = 32'(rate_bcd_ff);
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_STAT >> 2) begin
      rd_mux = {20'h0, view_ff, edit_ff, sel_ff, state_ff};
    end else if (AVS_ADDRESS[7:2] == `BFP_REG_LIN_NUM >> 2) begin
      rd_mux = 32'(lin_num_ff);
    end else if (AVS_ADDRESS >= `BFP_REG_LIN_BASE && AVS_ADDRESS < `BFP_REG_LIN_BASE + 8'h28) begin
      rd_mux = lin_ff[4'(AVS_ADDRESS[7:2] - 6'h08)];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wait_ff <= 1'b1;
      AVS_READDATA <= 32'h0;
      ctrl_ff <= `BFP_CTRL_RST;
      limit_ff <= `BFP_LIMIT_RST;
      qty_ff <= `BFP_QTY_RST;
      lin_num_ff <= `BFP_LIN_NUM_RST;
      for (int i = 0; i < `BFP_LIN_POINTS; i++) begin
        lin_ff[i] <= 32'h0;
      end
    end else begin
      wait_ff <= ~((AVS_READ | AVS_WRITE) & wait_ff);
      if (AVS_READ && wait_ff) begin
        AVS_READDATA <= rd_mux;
      end
      if (commit) begin
        qty_ff <= edit_qty_ff;
      end else if (bus_wr && AVS_ADDRESS[7:2] == `BFP_REG_QTY >> 2) begin
        qty_ff <= AVS_WRITEDATA[23:0];
      end
      if (bus_wr) begin
        if (AVS_ADDRESS[7:2] == `BFP_REG_CTRL >> 2) begin
          ctrl_ff <= AVS_WRITEDATA[2:0];
        end else if (AVS_ADDRESS[7:2] == `BFP_REG_LIMIT >> 2) begin
          limit_ff <= AVS_WRITEDATA[23:0];
        end else if (AVS_ADDRESS[7:2] == `BFP_REG_LIN_NUM >> 2) begin
          lin_num_ff <= (AVS_WRITEDATA[3:0] > 4'hA) ? 4'hA : AVS_WRITEDATA[3:0];
        end else if (AVS_ADDRESS >= `BFP_REG_LIN_BASE && AVS_ADDRESS < `BFP_REG_LIN_BASE + 8'h28) begin
          lin_ff[4'(AVS_ADDRESS[7:2] - 6'h08)] <= AVS_WRITEDATA;
        end
      end
    end
  end

  assign AVS_WAITREQUEST = wait_ff;

endmodule

// >>> verification/bfp_panel_asserts.sv
// Port checker of the batch front-panel controller.
`timescale 1ns/1ns
module bfp_panel_asserts import bfp_pkg::*; #(
  parameter int unsigned REFRESH_CYC = 10,
  parameter int unsigned PULSE_LOW_CYC = 5,
  parameter int unsigned PULSE_GAP_CYC = 12
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire bfp_disp_s DISP,
  input wire logic RELAY_1,
  input wire logic RELAY_2,
  input wire logic PULSE_OUT_N
);
  logic [31:0] low_ff, since_ff, chg_ff;
  logic seen_ff, pq_ff, disp_chg;
  bfp_disp_s dq_ff;
  assign disp_chg = (DISP != dq_ff);
  // Only the gap counter saturates, so a long idle spell cannot wrap it; the change counter does not.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      low_ff <= '0;
      since_ff <= 32'h0000FFFF;
      chg_ff <= '0;
      seen_ff <= 1'b0;
      pq_ff <= 1'b1;
      dq_ff <= '0;
    end else begin
      low_ff <= PULSE_OUT_N ? 32'h0 : low_ff + 32'h1;
      if (pq_ff && !PULSE_OUT_N) begin
        since_ff <= 32'h1;
      end else if (since_ff < 32'h0000FFFF) begin
        since_ff <= since_ff + 32'h1;
      end
      chg_ff <= disp_chg ? 32'h1 : chg_ff + 32'h1;
      seen_ff <= seen_ff | disp_chg;
      pq_ff <= PULSE_OUT_N;
      dq_ff <= DISP;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered after one wait cycle");
  AST_WAIT_SHORT: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_NO_SPUR: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest dropped without a request");
  AST_RDATA: assert property ($changed(AVS_READDATA) |-> !AVS_WAITREQUEST && $past(AVS_READ))
    else $error("read data changed outside a read answer");
  AST_PULSE_LOW: assert property ($rose(PULSE_OUT_N) |-> low_ff == PULSE_LOW_CYC)
    else $error("output pulse width wrong");
  AST_PULSE_GAP: assert property ($fell(PULSE_OUT_N) |-> since_ff >= PULSE_GAP_CYC)
    else $error("output pulses too close");
  AST_REFRESH: assert property (disp_chg && seen_ff |-> chg_ff % REFRESH_CYC == 0)
    else $error("display changed off the refresh period");
  AST_LABEL_DARK: assert property (DISP.label != BFP_L_NONE |-> DISP.digits == 24'h000000)
    else $error("digits shown under a label");
  AST_RELAYS: assert property (RELAY_1 == RELAY_2)
    else $error("relays switched apart");
  cover property ($fell(PULSE_OUT_N));
  cover property (DISP.label == BFP_L_SET);
  cover property ($fell(RELAY_1));
endmodule

// >>> verification/bfp_operator.sv
// Operator keypad and flowmeter model for the panel's far side.
`timescale 1ns/1ns
module bfp_operator import bfp_pkg::*; (
  input wire logic CLK_SYS,
  output bfp_keys_s KEYS,
  output logic FLOW_A,
  output logic FLOW_B
);
  initial begin
    KEYS = '0;
    FLOW_A = 1'b0;
    FLOW_B = 1'b0;
  end
  // Every press starts with a contact bounce shorter than the debounce window.
  task automatic press(input int idx);
    logic [3:0] k;
    k = 4'h0;
    k[idx] = 1'b1;
    @(posedge CLK_SYS) KEYS <= k;
    @(posedge CLK_SYS) KEYS <= '0;
    @(posedge CLK_SYS) KEYS <= k;
    repeat (14) @(posedge CLK_SYS);
    KEYS <= '0;
    repeat (14) @(posedge CLK_SYS);
  endtask
  // Forward quadrature: A rises while B is low.
  task automatic flow(input int n);
    repeat (n) begin
      @(posedge CLK_SYS) FLOW_A <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      FLOW_B <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      FLOW_A <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      FLOW_B <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
    end
  endtask
  // Reverse quadrature: A rises while B is high, which quadrature mode must not count.
  task automatic rev(input int n);
    repeat (n) begin
      @(posedge CLK_SYS) FLOW_B <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      FLOW_A <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      FLOW_B <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      FLOW_A <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
    end
  endtask
endmodule

// >>> verification/bfp_panel_tb.sv
// Self-checking bench of the batch front-panel controller.
`timescale 1ns/1ns
module bfp_panel_tb import bfp_pkg::*;;
  localparam int LABEL_CYC = 40;
  localparam int REFRESH_CYC = 10;
  localparam int K_BATCH = 3;
  localparam int K_DISP = 2;
  localparam int K_RUN = 1;
  localparam int K_STOP = 0;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, flow_a, flow_b, pout_q;
  logic led_batch, led_run, led_stop, relay_1, relay_2, pulse_out_n;
  bfp_keys_s keys;
  bfp_disp_s disp;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int npulse = 0;
  logic [31:0] seed = 32'h955CA274;
  always #20 clk_sys = ~clk_sys;
  bfp_operator op (.CLK_SYS(clk_sys), .KEYS(keys), .FLOW_A(flow_a), .FLOW_B(flow_b));
  // The rate gate keeps its full length, so rate stays zero here and the first table factor applies flat.
  bfp_panel #(.LABEL_CYC(LABEL_CYC), .REFRESH_CYC(REFRESH_CYC), .PULSE_LOW_CYC(5), .PULSE_GAP_CYC(12),
    .DEBOUNCE_CYC(4)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .KEYS(keys),
    .FLOW_A(flow_a), .FLOW_B(flow_b), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .DISP(disp), .LED_BATCH(led_batch), .LED_RUN(led_run),
    .LED_STOP(led_stop), .RELAY_1(relay_1), .RELAY_2(relay_2), .PULSE_OUT_N(pulse_out_n));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [23:0] inc_msd(input logic [23:0] q, input int n);
    q[23:20] = 4'((q[23:20] + n) % 10);
    return q;
  endfunction
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    pout_q <= pulse_out_n;
    if (pout_q === 1'b1 && pulse_out_n === 1'b0) begin
      npulse <= npulse + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // The request stands until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic settle();
    repeat (60) @(posedge clk_sys);
  endtask
  initial begin
    int n;
    int tg;
    logic ls_q;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(pulse_out_n, 1'b1);
    rd(8'h18, 32'hF0F, 32'h101);
    wr(8'h08, 32'h000123);
    rd(8'h08, 32'hFFFFFF, 32'h000123);
    rd(8'hFC, 32'hFFFFFFFF, 32'h0);
    wr(8'h04, 32'h000200);
    op.press(K_BATCH);
    chk(led_batch, 1'b1);
    chk(disp.label, BFP_L_BATCH);
    rd(8'h18, 32'hFF, 32'hD1);
    repeat (LABEL_CYC + 2 * REFRESH_CYC) @(posedge clk_sys);
    chk(disp.digits, 24'h000123);
    op.press(K_DISP);
    op.press(K_BATCH);
    rd(8'h18, 32'h80, 32'h80);
    rd(8'h08, 32'hFFFFFF, 32'h000123);
    op.press(K_BATCH);
    rd(8'h18, 32'h80, 32'h00);
    wr(8'h04, 32'h0);
    seed = lfsr(seed);
    n = int'(seed[3:0]) + 1;
    op.press(K_BATCH);
    repeat (n) op.press(K_DISP);
    op.press(K_RUN);
    rd(8'h18, 32'h70, 32'h40);
    repeat (5) op.press(K_RUN);
    rd(8'h18, 32'h70, 32'h50);
    op.press(K_BATCH);
    chk(disp.label, BFP_L_SET);
    chk(led_batch, 1'b0);
    rd(8'h08, 32'hFFFFFF, {8'h0, inc_msd(24'h000123, n)});
    wr(8'h08, 32'h000003);
    wr(8'h00, 32'h0);
    op.press(K_RUN);
    chk({relay_1, led_run}, 2'b11);
    op.flow(2);
    settle();
    rd(8'h0C, 32'hFFFFFF, 32'h2);
    chk(npulse, 2);
    op.press(K_STOP);
    chk(relay_1, 1'b0);
    rd(8'h18, 32'hF, 32'h4);
    tg = 0;
    ls_q = led_stop;
    repeat (4 * REFRESH_CYC) begin
      @(posedge clk_sys);
      if (led_stop !== ls_q) tg++;
      ls_q = led_stop;
    end
    chk(tg >= 2, 1'b1);
    op.flow(1);
    settle();
    rd(8'h0C, 32'hFFFFFF, 32'h2);
    rd(8'h10, 32'hFFFFFF, 32'h3);
    op.press(K_RUN);
    rd(8'h18, 32'hF, 32'h2);
    op.flow(1);
    settle();
    rd(8'h18, 32'hF, 32'h8);
    op.press(K_STOP);
    rd(8'h0C, 32'hFFFFFF, 32'h0);
    rd(8'h10, 32'hFFFFFF, 32'h4);
    chk(npulse, 4);
    wr(8'h00, 32'h1);
    op.press(K_RUN);
    rd(8'h0C, 32'hFFFFFF, 32'h3);
    op.flow(3);
    settle();
    rd(8'h18, 32'hF, 32'h8);
    op.press(K_STOP);
    rd(8'h0C, 32'hFFFFFF, 32'h3);
    wr(8'h00, 32'h2);
    op.press(K_RUN);
    op.flow(3);
    settle();
    op.press(K_RUN);
    rd(8'h18, 32'hF, 32'h2);
    rd(8'h0C, 32'hFFFFFF, 32'h0);
    op.press(K_BATCH);
    tg = 0;
    repeat (LABEL_CYC + 2 * REFRESH_CYC) begin
      @(posedge clk_sys);
      if (disp.blank === 6'h3F) tg = 1;
    end
    chk(tg, 1);
    op.press(K_DISP);
    op.press(K_BATCH);
    rd(8'h08, 32'hFFFFFF, 32'h3);
    rd(8'h18, 32'h8F, 32'h02);
    op.press(K_STOP);
    op.press(K_STOP);
    rd(8'h18, 32'hF, 32'h1);
    wr(8'h00, 32'h4);
    op.rev(2);
    op.flow(1);
    settle();
    rd(8'h10, 32'hFFFFFF, 32'h11);
    wr(8'h20, 32'h2000);
    wr(8'h1C, 32'h1);
    op.flow(1);
    settle();
    rd(8'h10, 32'hFFFFFF, 32'h13);
    op.press(K_DISP);
    chk(disp.label, BFP_L_RATE);
    rd(8'h18, 32'hF00, 32'h200);
    op.press(K_DISP);
    chk(disp.label, BFP_L_GRAND);
    rd(8'h18, 32'hF00, 32'h400);
    tally_and_finish();
  end
endmodule
// The checker's default timing equals the shortened values that the bench gives the panel.
bind bfp_panel bfp_panel_asserts chk_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DISP(DISP),
  .RELAY_1(RELAY_1), .RELAY_2(RELAY_2), .PULSE_OUT_N(PULSE_OUT_N));
